// ==== design/nvwc_cfg.svh ====
`ifndef NVWC_CFG_SVH
`define NVWC_CFG_SVH

// Serial frame layout
`define NVWC_FRAME_BITS 24
`define NVWC_CNT_W 5
`define NVWC_OPC_HI 23
`define NVWC_OPC_LO 20
`define NVWC_ADR_HI 19
`define NVWC_ADR_LO 16
`define NVWC_DAT_HI 15
`define NVWC_WIPER_W 10
`define NVWC_NV_W 16
`define NVWC_NV_DEPTH 16

// Wiper codes
`define NVWC_MIDSCALE 10'h200
`define NVWC_FULLSCALE 10'h3FF
`define NVWC_ZERO 10'h000

// Nonvolatile map and reset contents
`define NVWC_ADDR_WIPER 4'h0
`define NVWC_ADDR_OUTS 4'h1
`define NVWC_BIT_OUT1 0
`define NVWC_BIT_OUT2 1
`define NVWC_OUTS_DEFAULT 16'h0003
`define NVWC_NV_BLANK 16'h0000

// Idle pin levels {preset, protect, data in, select, link clock}
`define NVWC_PIN_IDLE 5'h1A

// Timing
`define NVWC_CLK_MHZ 125
`define NVWC_STORE_MS 25
`define NVWC_STORE_CYCLES (`NVWC_STORE_MS * `NVWC_CLK_MHZ * 1000)
`define NVWC_OP_CYCLES 8
`define NVWC_BUSY_W 22

`endif

// ==== design/nvwc_core.sv ====
`timescale 1ns/1ns
`include "nvwc_cfg.svh"

// Functional notes
// - Write-protect low blocks changes except restores, preset
// - Nonvolatile wiper defaults to midscale 512
// - Preset low forces midscale; rising edge reloads
// - Commands execute only on chip-select rise
// - Ready marks completion of 1,2,3,8,9,10, preset
// - Second output follows D1 at address 1
// - Wiper tap follows wiper register always
// - Store lasts 25 ms, shift register locked
// - Ready pulses low until store finishes
// - Opcode 2 stores wiper; opcode 3 stores addressed
// - Opcode 3 address selects wiper or user word
// - Opcodes 1 and 8 reload wiper from store
// - Opcode B address 0 writes data to wiper
// - Opcodes 4,5 halve; 12,13 double wiper
// - Opcodes 6,7 decrement; 14,15 increment one step
// - Bare chip-select strobe repeats step/shift command
// - Opcode 9 reads store; 10 reads wiper
// - Power-on loads wiper from nonvolatile store
// - Serial output shifts previous frame otherwise
// - 24-bit frames, MSB first: opcode, address, data
// - One input bit per serial clock rise
// - First output follows D0 at address 1
module nvwc_core
    import nvwc_pkg::*;
#(
    parameter int STORE_CYCLES = `NVWC_STORE_CYCLES,
    parameter int OP_CYCLES = `NVWC_OP_CYCLES
)(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Serial link pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    // Control pins
    input wire logic wp_n_i,
    input wire logic preset_n_i,
    output logic ready_o,
    // Wiper and latched outputs
    output logic [`NVWC_WIPER_W-1:0] wiper_o,
    output logic nv_out_first_o,
    output logic nv_out_second_o
);

    localparam int NSYNC = 5;

    // Two-stage synchronisers for every pin input
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic sclk_d;
    logic cs_d;
    logic pr_d;
    wire logic sclk_s = sync_b[0];
    wire logic cs_s = sync_b[1];
    wire logic sin_s = sync_b[2];
    wire logic wp_s = sync_b[3];
    wire logic pr_s = sync_b[4];

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // Idle levels, so no false link clock edge follows reset
            sync_a <= `NVWC_PIN_IDLE;
            sync_b <= `NVWC_PIN_IDLE;
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
            pr_d <= 1'b1;
        end
        else
        begin
            sync_a <= {preset_n_i, wp_n_i, serial_in_i, cs_n_i, sclk_i};
            sync_b <= sync_a;
            sclk_d <= sclk_s;
            cs_d <= cs_s;
            pr_d <= pr_s;
        end
    end

    wire logic sclk_rise = sclk_s & ~sclk_d;
    wire logic cs_rise = cs_s & ~cs_d;
    wire logic pr_rise = pr_s & ~pr_d;

    // Nonvolatile store array, held in flops for this model
    logic [`NVWC_NV_W-1:0] nv_mem [`NVWC_NV_DEPTH];
    logic mem_we;
    logic [3:0] mem_addr;
    logic [`NVWC_NV_W-1:0] mem_data;

    // Control state
    nvwc_state_t state, next_state;
    logic [`NVWC_FRAME_BITS-1:0] shift_reg, next_shift_reg;
    logic [`NVWC_CNT_W-1:0] bit_cnt, next_bit_cnt;
    logic any_clk, next_any_clk;
    logic [`NVWC_FRAME_BITS-1:0] last_frame, next_last_frame;
    logic last_rep, next_last_rep;
    logic [`NVWC_WIPER_W-1:0] wiper, next_wiper;
    logic [`NVWC_BUSY_W-1:0] busy_cnt, next_busy_cnt;
    logic [`NVWC_BUSY_W-1:0] busy_lim, next_busy_lim;
    logic pend_we, next_pend_we;
    logic [3:0] pend_addr, next_pend_addr;
    logic [`NVWC_NV_W-1:0] pend_data, next_pend_data;
    logic ready, next_ready;
    logic sdo_bit, next_sdo_bit;
    logic sdo_oe, next_sdo_oe;

    localparam logic [`NVWC_BUSY_W-1:0] STORE_LIM = `NVWC_BUSY_W'(STORE_CYCLES - 1);
    localparam logic [`NVWC_BUSY_W-1:0] OP_LIM = `NVWC_BUSY_W'(OP_CYCLES - 1);

    // Step and shift commands may be replayed by a bare strobe
    function automatic logic is_repeatable(input logic [3:0] op);
        is_repeatable = (op[3:2] == 2'b01) || (op[3:2] == 2'b11);
    endfunction

    // Main sequencer: decode, execute, time the busy window
    always_comb
    begin
        logic [`NVWC_FRAME_BITS-1:0] frm;
        logic [3:0] op;
        logic [3:0] adr;
        logic do_exec;
        frm = shift_reg;
        op = 4'h0;
        adr = 4'h0;
        do_exec = 1'b0;
        next_state = state;
        next_shift_reg = shift_reg;
        next_bit_cnt = bit_cnt;
        next_any_clk = any_clk;
        next_last_frame = last_frame;
        next_last_rep = last_rep;
        next_wiper = wiper;
        next_busy_cnt = busy_cnt;
        next_busy_lim = busy_lim;
        next_pend_we = pend_we;
        next_pend_addr = pend_addr;
        next_pend_data = pend_data;
        next_ready = ready;
        mem_we = 1'b0;
        mem_addr = pend_addr;
        mem_data = pend_data;

        // Shifting stays frozen while busy, so a store cannot be disturbed
        if (state != NVWC_ST_BUSY && !cs_s && sclk_rise)
        begin
            next_shift_reg = {shift_reg[`NVWC_FRAME_BITS-2:0], sin_s};
            next_any_clk = 1'b1;
            if (bit_cnt == `NVWC_CNT_W'(`NVWC_FRAME_BITS - 1))
                next_bit_cnt = '0;
            else
                next_bit_cnt = bit_cnt + 1'b1;
        end

        case (state)
            NVWC_ST_POWERUP:
            begin
                next_wiper = nv_mem[`NVWC_ADDR_WIPER][`NVWC_WIPER_W-1:0];
                next_busy_cnt = '0;
                next_busy_lim = OP_LIM;
                next_state = NVWC_ST_BUSY;
            end
            NVWC_ST_IDLE:
            begin
                next_ready = 1'b1;
                if (!pr_s)
                begin
                    next_wiper = `NVWC_MIDSCALE;
                    next_ready = 1'b0;
                    next_state = NVWC_ST_PRESET;
                end
                else if (cs_rise)
                begin
                    next_bit_cnt = '0;
                    next_any_clk = 1'b0;
                    // Bare strobe replays; partial frames are dropped
                    if (!any_clk && last_rep)
                    begin
                        frm = last_frame;
                        do_exec = 1'b1;
                    end
                    else if (any_clk && bit_cnt == '0)
                    begin
                        frm = shift_reg;
                        do_exec = 1'b1;
                    end
                end
                if (do_exec)
                begin
                    op = frm[`NVWC_OPC_HI:`NVWC_OPC_LO];
                    adr = frm[`NVWC_ADR_HI:`NVWC_ADR_LO];
                    next_last_frame = frm;
                    next_last_rep = is_repeatable(op) && wp_s;
                    next_busy_cnt = '0;
                    case (nvwc_opcode_t'(op))
                        NVWC_OP_RESTORE, NVWC_OP_RELOAD:
                        begin
                            next_wiper = nv_mem[`NVWC_ADDR_WIPER][`NVWC_WIPER_W-1:0];
                            next_busy_lim = OP_LIM;
                            next_ready = 1'b0;
                            next_state = NVWC_ST_BUSY;
                        end
                        NVWC_OP_STORE_WIPER, NVWC_OP_STORE_DATA:
                        begin
                            if (wp_s)
                            begin
                                next_pend_we = 1'b1;
                                next_pend_addr = (op == NVWC_OP_STORE_WIPER) ? `NVWC_ADDR_WIPER : adr;
                                next_pend_data = (next_pend_addr == `NVWC_ADDR_WIPER) ?
                                    `NVWC_NV_W'(wiper) : frm[`NVWC_DAT_HI:0];
                                next_busy_lim = STORE_LIM;
                                next_ready = 1'b0;
                                next_state = NVWC_ST_BUSY;
                            end
                        end
                        NVWC_OP_DEC6_A, NVWC_OP_DEC6_B:
                            if (wp_s)
                                next_wiper = wiper >> 1;
                        NVWC_OP_INC6_A, NVWC_OP_INC6_B:
                            if (wp_s)
                                next_wiper = wiper[`NVWC_WIPER_W-1] ? `NVWC_FULLSCALE : (wiper << 1);
                        NVWC_OP_DEC1_A, NVWC_OP_DEC1_B:
                            if (wp_s && wiper != `NVWC_ZERO)
                                next_wiper = wiper - 1'b1;
                        NVWC_OP_INC1_A, NVWC_OP_INC1_B:
                            if (wp_s && wiper != `NVWC_FULLSCALE)
                                next_wiper = wiper + 1'b1;
                        NVWC_OP_READ_NV, NVWC_OP_READ_WIPER:
                        begin
                            // Readback word replaces the echo for the next frame
                            next_shift_reg = (op == NVWC_OP_READ_NV) ?
                                `NVWC_FRAME_BITS'(nv_mem[adr]) : `NVWC_FRAME_BITS'(wiper);
                            next_busy_lim = OP_LIM;
                            next_ready = 1'b0;
                            next_state = NVWC_ST_BUSY;
                        end
                        NVWC_OP_WRITE:
                            if (wp_s && adr == `NVWC_ADDR_WIPER)
                                next_wiper = frm[`NVWC_WIPER_W-1:0];
                        default:
                            next_wiper = wiper;
                    endcase
                end
            end
            NVWC_ST_PRESET:
            begin
                next_ready = 1'b0;
                if (pr_rise)
                begin
                    next_wiper = nv_mem[`NVWC_ADDR_WIPER][`NVWC_WIPER_W-1:0];
                    next_busy_cnt = '0;
                    next_busy_lim = OP_LIM;
                    next_state = NVWC_ST_BUSY;
                end
                else
                    next_wiper = `NVWC_MIDSCALE;
            end
            NVWC_ST_BUSY:
            begin
                next_ready = 1'b0;
                // Strobes seen while locked are consumed, not replayed later
                next_bit_cnt = '0;
                next_any_clk = 1'b0;
                if (busy_cnt == busy_lim)
                begin
                    mem_we = pend_we;
                    next_pend_we = 1'b0;
                    next_ready = 1'b1;
                    next_state = NVWC_ST_IDLE;
                end
                else
                    next_busy_cnt = busy_cnt + 1'b1;
            end
            default:
                next_state = NVWC_ST_IDLE;
        endcase

        // Open-drain output only pulls low inside a frame
        next_sdo_bit = next_shift_reg[`NVWC_FRAME_BITS-1];
        next_sdo_oe = !cs_s && !next_shift_reg[`NVWC_FRAME_BITS-1];
    end

    // State registers
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= NVWC_ST_POWERUP;
            shift_reg <= '0;
            bit_cnt <= '0;
            any_clk <= 1'b0;
            last_frame <= '0;
            last_rep <= 1'b0;
            wiper <= `NVWC_MIDSCALE;
            busy_cnt <= '0;
            busy_lim <= '0;
            pend_we <= 1'b0;
            pend_addr <= '0;
            pend_data <= '0;
            ready <= 1'b0;
            sdo_bit <= 1'b0;
            sdo_oe <= 1'b0;
        end
        else
        begin
            state <= next_state;
            shift_reg <= next_shift_reg;
            bit_cnt <= next_bit_cnt;
            any_clk <= next_any_clk;
            last_frame <= next_last_frame;
            last_rep <= next_last_rep;
            wiper <= next_wiper;
            busy_cnt <= next_busy_cnt;
            busy_lim <= next_busy_lim;
            pend_we <= next_pend_we;
            pend_addr <= next_pend_addr;
            pend_data <= next_pend_data;
            ready <= next_ready;
            sdo_bit <= next_sdo_bit;
            sdo_oe <= next_sdo_oe;
        end
    end

    // Nonvolatile array; reset models the factory contents
    generate
        for (genvar i = 0; i < `NVWC_NV_DEPTH; i++)
        begin : g_nv
            localparam logic [`NVWC_NV_W-1:0] INIT = (i == `NVWC_ADDR_WIPER) ? `NVWC_NV_W'(`NVWC_MIDSCALE) :
                (i == `NVWC_ADDR_OUTS) ? `NVWC_OUTS_DEFAULT : `NVWC_NV_BLANK;
            always_ff @(posedge clock_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    nv_mem[i] <= INIT;
                else if (mem_we && mem_addr == 4'(i))
                    nv_mem[i] <= mem_data;
            end
        end
    endgenerate

    // Outputs straight from flops
    assign wiper_o = wiper;
    assign ready_o = ready;
    assign serial_out_o = sdo_bit;
    assign serial_out_oe_o = sdo_oe;
    assign nv_out_first_o = nv_mem[`NVWC_ADDR_OUTS][`NVWC_BIT_OUT1];
    assign nv_out_second_o = nv_mem[`NVWC_ADDR_OUTS][`NVWC_BIT_OUT2];

endmodule // nvwc_core

// ==== design/nvwc_pkg.sv ====
package nvwc_pkg;

    // Instruction codes carried in the top nibble of a frame
    typedef enum logic [3:0] {
        NVWC_OP_NOP = 4'h0,
        NVWC_OP_RESTORE = 4'h1,
        NVWC_OP_STORE_WIPER = 4'h2,
        NVWC_OP_STORE_DATA = 4'h3,
        NVWC_OP_DEC6_A = 4'h4,
        NVWC_OP_DEC6_B = 4'h5,
        NVWC_OP_DEC1_A = 4'h6,
        NVWC_OP_DEC1_B = 4'h7,
        NVWC_OP_RELOAD = 4'h8,
        NVWC_OP_READ_NV = 4'h9,
        NVWC_OP_READ_WIPER = 4'hA,
        NVWC_OP_WRITE = 4'hB,
        NVWC_OP_INC6_A = 4'hC,
        NVWC_OP_INC6_B = 4'hD,
        NVWC_OP_INC1_A = 4'hE,
        NVWC_OP_INC1_B = 4'hF
    } nvwc_opcode_t;

    typedef enum logic [1:0] {
        NVWC_ST_POWERUP,
        NVWC_ST_IDLE,
        NVWC_ST_BUSY,
        NVWC_ST_PRESET
    } nvwc_state_t;

endpackage

// ==== test/nvwc_assertions.sv ====
`timescale 1ns/1ns
`include "nvwc_cfg.svh"
module nvwc_assertions #(
    parameter int STORE_CYCLES = 50,
    parameter int OP_CYCLES = 8
)(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Serial link
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic serial_in_i,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_o,
    // Control
    input wire logic wp_n_i,
    input wire logic preset_n_i,
    input wire logic ready_o,
    // Outputs
    input wire logic [`NVWC_WIPER_W-1:0] wiper_o,
    input wire logic nv_out_first_o,
    input wire logic nv_out_second_o
);
    int low_cnt, next_low_cnt;
    logic armed, next_armed, dirty, next_dirty;

    // Busy length; a preset spoils the window since its low phase is unbounded
    always_comb
    begin
        next_low_cnt = ready_o ? 0 : low_cnt + 1;
        next_armed = armed | ready_o;
        next_dirty = ready_o ? 1'b0 : (dirty | ~preset_n_i);
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            low_cnt <= 0;
            armed <= 1'b0;
            dirty <= 1'b0;
        end
        else
        begin
            low_cnt <= next_low_cnt;
            armed <= next_armed;
            dirty <= next_dirty;
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    a_oe_when_idle: assert property (cs_n_i [*6] |-> !serial_out_oe_o)
        else $error("serial out driven while deselected");
    a_oe_drives_zero: assert property (serial_out_oe_o |-> !serial_out_o)
        else $error("open drain enabled for a one");
    a_quiet_select: assert property ((!cs_n_i && preset_n_i) [*8] |-> $stable(wiper_o))
        else $error("wiper moved while selected");
    a_busy_length: assert property ($rose(ready_o) && armed && !dirty |->
        (low_cnt == OP_CYCLES) || (low_cnt == STORE_CYCLES))
        else $error("busy window length wrong");
    a_wp_freeze: assert property ((!wp_n_i && ready_o && preset_n_i) [*8] |->
        $stable(wiper_o) && $stable({nv_out_first_o, nv_out_second_o}))
        else $error("change while write protected");
    a_nv_at_commit: assert property ($changed({nv_out_first_o, nv_out_second_o}) |->
        !$past(ready_o) || !$past(ready_o, 2))
        else $error("latched output moved outside a store");
    a_preset_mid: assert property (ready_o ##1 !preset_n_i [*6] |-> wiper_o == `NVWC_MIDSCALE)
        else $error("preset did not force midscale");
    a_ready_cause: assert property ($fell(ready_o) |->
        $past(cs_n_i, 3) || !$past(preset_n_i, 3) || !$past(preset_n_i, 4))
        else $error("ready fell without cause");

    c_store: cover property ($rose(ready_o) && low_cnt == STORE_CYCLES);
    c_wp_restore: cover property (!wp_n_i && $fell(ready_o));
    c_preset: cover property ($fell(preset_n_i));
endmodule // nvwc_assertions

bind nvwc_core nvwc_assertions #(.STORE_CYCLES(STORE_CYCLES), .OP_CYCLES(OP_CYCLES)) i_nvwc_assertions (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .serial_in_i(serial_in_i),
    .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o), .wp_n_i(wp_n_i),
    .preset_n_i(preset_n_i), .ready_o(ready_o), .wiper_o(wiper_o),
    .nv_out_first_o(nv_out_first_o), .nv_out_second_o(nv_out_second_o));

// ==== test/nvwc_host_model.sv ====
`timescale 1ns/1ns
module nvwc_host_model (
    // Clock
    input wire logic clock_i,
    // Serial link pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic serial_in_o,
    input wire logic serial_out_i
);
    // Link clock parked low and deselected between frames
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        serial_in_o = 1'b0;
    end

    // Half of the 160 ns link period
    task automatic half();
        repeat (10) @(negedge clock_i);
    endtask

    // One frame, MSB first; wire sampled just before each rise
    task automatic frame(input logic [23:0] w, output logic [23:0] rx);
        cs_n_o = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            serial_in_o = w[i];
            half();
            rx[i] = serial_out_i;
            sclk_o = 1'b1;
            half();
            sclk_o = 1'b0;
        end
        half();
        cs_n_o = 1'b1;
        serial_in_o = ~w[0]; // Released line: never the last value
        half();
    endtask

    // Select pulse with no link clock
    task automatic strobe();
        cs_n_o = 1'b0;
        half();
        cs_n_o = 1'b1;
        half();
    endtask
endmodule // nvwc_host_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
`include "nvwc_cfg.svh"
module tb_top;
    logic clock_i, rst_n_i, sclk, cs_n, serial_in, serial_out, sdo_oe, sdo_wire, wp_n, preset_n, ready, out1, out2;
    logic [`NVWC_WIPER_W-1:0] wiper;
    logic [23:0] rx;
    int failures = 0;
    int num_checks = 0;

    // Pull-up on the open-drain data line
    assign sdo_wire = sdo_oe ? 1'b0 : 1'b1;

    nvwc_core #(.STORE_CYCLES(50), .OP_CYCLES(8)) i_nvwc_core (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .sclk_i(sclk), .cs_n_i(cs_n), .serial_in_i(serial_in), .serial_out_o(serial_out), .serial_out_oe_o(sdo_oe),
        .wp_n_i(wp_n), .preset_n_i(preset_n), .ready_o(ready), .wiper_o(wiper),
        .nv_out_first_o(out1), .nv_out_second_o(out2));
    nvwc_host_model i_nvwc_host_model (.clock_i(clock_i), .sclk_o(sclk), .cs_n_o(cs_n),
        .serial_in_o(serial_in), .serial_out_i(sdo_wire));

    initial
    begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait: a hung busy flag must not stall the run
    task automatic wait_ready();
        int n;
        n = 0;
        repeat (8) @(negedge clock_i);
        while (ready !== 1'b1 && n < 1000)
        begin
            @(negedge clock_i);
            n++;
        end
        check({23'h0, ready}, 24'h000001);
    endtask

    task automatic send(input logic [23:0] w);
        i_nvwc_host_model.frame(w, rx);
        wait_ready();
    endtask

    task automatic t_power();
        check({14'h0, wiper}, 24'h000200);
        check({22'h0, out1, out2}, 24'h000003);
        $display("test power done");
    endtask

    task automatic t_store();
        send(24'hB00100);
        check({14'h0, wiper}, 24'h000100);
        send(24'h200000);
        check(rx, 24'hB00100);
        send(24'hB00033);
        send(24'h900000);
        send(24'h000000);
        check(rx, 24'h000100);
        send(24'h800000);
        check({14'h0, wiper}, 24'h000100);
        preset_n = 1'b0;
        repeat (10) @(negedge clock_i);
        check({14'h0, wiper}, 24'h000200);
        preset_n = 1'b1;
        wait_ready();
        check({14'h0, wiper}, 24'h000100);
        $display("test store done");
    endtask

    // Bit 24 marks a bare select strobe
    task automatic t_steps();
        logic [24:0] seq [13] = '{25'h0B00155, 25'h0E00000, 25'h1000000, 25'h0600000, 25'h0700000,
            25'h0C00000, 25'h0D00000, 25'h0F00000, 25'h0400000, 25'h0500000, 25'h1000000,
            25'h0B00000, 25'h0600000};
        logic [9:0] exp [13] = '{10'h155, 10'h156, 10'h157, 10'h156, 10'h155, 10'h2AA, 10'h3FF,
            10'h3FF, 10'h1FF, 10'h0FF, 10'h07F, 10'h000, 10'h000};
        for (int i = 0; i < 13; i++)
        begin
            if (seq[i][24])
                i_nvwc_host_model.strobe();
            else
                i_nvwc_host_model.frame(seq[i][23:0], rx);
            wait_ready();
            check({14'h0, wiper}, {14'h0, exp[i]});
        end
        $display("test steps done");
    endtask

    task automatic t_wp();
        wp_n = 1'b0;
        repeat (4) @(negedge clock_i);
        send(24'hB00005);
        check({14'h0, wiper}, 24'h000000);
        send(24'h310000);
        check({22'h0, out1, out2}, 24'h000003);
        send(24'h100000);
        check({14'h0, wiper}, 24'h000100);
        send(24'h000000);
        wp_n = 1'b1;
        $display("test protect done");
    endtask

    task automatic t_outs();
        i_nvwc_host_model.frame(24'h310002, rx);
        check({23'h0, ready}, 24'h000000);
        wait_ready();
        check({22'h0, out1, out2}, 24'h000001);
        send(24'hA00000);
        send(24'h000000);
        check(rx, 24'h000100);
        $display("test outputs done");
    endtask

    task automatic test_done();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog at 50k cycles, well beyond the roughly 12k the tests need
    initial
    begin
        #400000;
        failures++;
        test_done();
    end

    initial
    begin
        rst_n_i = 1'b0;
        wp_n = 1'b1;
        preset_n = 1'b1;
        repeat (4) @(negedge clock_i);
        rst_n_i = 1'b1;
        wait_ready();
        repeat (4) @(negedge clock_i);
        t_power();
        t_store();
        t_steps();
        t_wp();
        t_outs();
        test_done();
    end
endmodule // tb_top
